// [hdl/sec_bus_pkg.sv]
// Shared constants and types for the secondary bus port
package sec_bus_pkg;
    localparam int DW = 32;
    localparam int CW = 4;
    localparam int NAGT = 9;
    localparam int NARB = 10;
    localparam logic [3:0] BRIDGE_IDX = 4'h9;
    localparam int FIFO_W = DW + CW;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam int LEN_W = 4;
    localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
    localparam logic [1:0] GNT_GAP = 2'h2;
    localparam logic [2:0] SYNC_RST = 3'h0;
    localparam logic [DW-1:0] PARK_AD = 32'h0000_0000;
    localparam logic [CW-1:0] PARK_CBE = 4'h0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_END = 5'b01000,
        ST_TURN = 5'b10000
    } mst_state_t;
endpackage

// [hdl/word_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int W = 36,
    parameter int D = 8,
    parameter int AW = 3
) (
    input wire logic core_clk, // Clock
    input wire logic rstn, // Async reset, active low
    input wire logic in_valid, // Write side valid
    output logic in_ready, // Write side ready
    input wire logic [W-1:0] in_data, // Write side word
    output logic out_valid, // Read side valid
    input wire logic out_ready, // Read side ready
    output logic [W-1:0] out_data, // Read side word
    output logic [AW:0] count // Words held
);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r < (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign count = cnt_r;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [hdl/secondary_bus_port.sv]
// Secondary bus port: initiator, parity, arbiter, parking and M66EN handling
`timescale 1ns/1ps
module secondary_bus_port (
    input wire logic core_clk, // Secondary bus clock
    input wire logic rstn, // Async reset, active low
    input wire logic [31:0] ad_i, // Address/data pins in
    output logic [31:0] ad_o, // Address/data pins out
    output logic ad_oe, // Address/data drive enable
    input wire logic [3:0] cbe_i, // Command/byte enable pins in
    output logic [3:0] cbe_o, // Command/byte enable out
    output logic cbe_oe, // Command/byte enable drive enable
    input wire logic par_i, // Parity pin in
    output logic par_o, // Parity out
    output logic par_oe, // Parity drive enable
    input wire logic frame_n_i, // Frame pin in
    output logic frame_n_o, // Frame out
    output logic frame_n_oe, // Frame drive enable
    input wire logic irdy_n_i, // Initiator ready pin in
    output logic irdy_n_o, // Initiator ready out
    output logic irdy_n_oe, // Initiator ready drive enable
    input wire logic trdy_n_i, // Target ready pin
    input wire logic devsel_n_i, // Device select pin
    input wire logic stop_n_i, // Target stop pin
    input wire logic lock_n_i, // Lock pin in
    output logic lock_n_o, // Lock out
    output logic lock_n_oe, // Lock drive enable
    input wire logic perr_n_i, // Parity error pin in
    output logic perr_n_o, // Parity error out
    output logic perr_n_oe, // Parity error drive enable
    input wire logic serr_n_i, // System error pin, input only
    input wire logic [8:0] sreq_n, // Agent requests
    output logic [8:0] gnt_n_o, // Agent grants
    input wire logic ext_arb, // Strap: external arbiter selected
    input wire logic p_m66en, // Primary speed line
    input wire logic s_m66en_i, // Secondary speed line in
    output logic s_m66en_o, // Secondary speed line out
    output logic s_m66en_oe, // Secondary speed line pull-down enable
    output logic clk_66_sel, // Secondary clock at fast rate
    input wire logic cmd_valid, // Transaction request
    output logic cmd_ready, // Transaction accepted
    input wire logic cmd_write, // Write when high
    input wire logic [31:0] cmd_addr, // Address
    input wire logic [3:0] cmd_code, // Bus command
    input wire logic [3:0] cmd_be, // Read byte enables
    input wire logic [3:0] cmd_len, // Words, 1 to 8
    input wire logic lock_hold, // Keep bus locked
    input wire logic wr_valid, // Write word valid
    output logic wr_ready, // Write word ready
    input wire logic [31:0] wr_data, // Write word
    input wire logic [3:0] wr_be, // Write byte enables
    output logic [31:0] rd_data, // Read word
    output logic rd_valid, // Read word pulse
    output logic done, // Transaction finished pulse
    output logic master_abort, // No device select pulse
    output logic target_stop, // Target stop pulse
    output logic perr_flag, // Own parity error pulse
    output logic bus_perr, // Other agent parity error pulse
    output logic serr_flag // System error seen pulse
);
    sec_bus_pkg::mst_state_t state_r;
    sec_bus_pkg::mst_state_t state_nxt;
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] filt_r;
    logic ext_f;
    logic p66_f;
    logic s66_f;
    logic [35:0] head;
    logic head_valid;
    logic pop;
    logic [3:0] fifo_cnt;
    logic [31:0] ad_r;
    logic [3:0] cbe_r;
    logic ad_oe_r;
    logic cbe_oe_r;
    logic par_r;
    logic par_oe_r;
    logic frame_act_r;
    logic irdy_act_r;
    logic ctl_oe_r;
    logic wr_r;
    logic [3:0] left_r;
    logic [3:0] drop_r;
    logic [2:0] dev_cnt_r;
    logic dev_seen_r;
    logic lock_own_r;
    logic lock_rel_r;
    logic chk_pend_r;
    logic [31:0] chk_ad_r;
    logic [3:0] chk_cbe_r;
    logic perr_act_r;
    logic perr_oe_r;
    logic [9:0] gnt_r;
    logic [9:0] gnt_nxt;
    logic [9:0] req_v;
    logic [9:0] elig;
    logic [3:0] last_r;
    logic [3:0] pick;
    logic found;
    logic used_r;
    logic [1:0] hold_r [sec_bus_pkg::NAGT];
    logic bus_idle;
    logic own_gnt;
    logic bridge_req;
    logic start;
    logic xfer;
    logic timeout;
    logic stop_hit;
    logic last_x;
    logic rearb;
    logic [31:0] rd_data_r;
    logic rd_valid_r;
    logic done_r;
    logic abort_r;
    logic stop_r;
    logic serr_r;
    logic bus_perr_r;
    logic clk66_r;

    // Straps and speed lines are asynchronous to this clock
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= sec_bus_pkg::SYNC_RST;
            s2_r <= sec_bus_pkg::SYNC_RST;
            s3_r <= sec_bus_pkg::SYNC_RST;
            filt_r <= sec_bus_pkg::SYNC_RST;
        end else begin
            s1_r <= {s_m66en_i, p_m66en, ext_arb};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
        end
    end
    assign ext_f = filt_r[0];
    assign p66_f = filt_r[1];
    assign s66_f = filt_r[2];

    word_fifo #(
        .W(sec_bus_pkg::FIFO_W),
        .D(sec_bus_pkg::FIFO_DEPTH),
        .AW(sec_bus_pkg::FIFO_AW)
    ) u_wr_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_be, wr_data}),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head),
        .count(fifo_cnt)
    );

    assign bus_idle = frame_n_i & irdy_n_i;
    assign own_gnt = ext_f ? ~sreq_n[0] : gnt_r[sec_bus_pkg::BRIDGE_IDX];
    assign bridge_req = (state_r == sec_bus_pkg::ST_IDLE) & cmd_valid & (drop_r == 4'h0);
    assign start = bridge_req & own_gnt & bus_idle & (~cmd_write | (fifo_cnt >= cmd_len))
                   & (~lock_hold | lock_own_r | lock_n_i);
    assign cmd_ready = start;
    assign xfer = irdy_act_r & ~trdy_n_i & ((state_r == sec_bus_pkg::ST_DATA) | (state_r == sec_bus_pkg::ST_END));
    assign timeout = ~dev_seen_r & devsel_n_i & (dev_cnt_r == sec_bus_pkg::DEVSEL_LIMIT);
    assign stop_hit = ~stop_n_i & ~devsel_n_i;
    assign last_x = xfer & (left_r == 4'h1);
    assign pop = (wr_r & xfer) | ((state_r == sec_bus_pkg::ST_IDLE) & (drop_r != 4'h0) & head_valid);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sec_bus_pkg::ST_IDLE: begin
                if (start) begin
                    state_nxt = sec_bus_pkg::ST_ADDR;
                end
            end
            sec_bus_pkg::ST_ADDR: begin
                state_nxt = sec_bus_pkg::ST_DATA;
            end
            sec_bus_pkg::ST_DATA: begin
                if (last_x) begin
                    state_nxt = sec_bus_pkg::ST_TURN;
                end else if (timeout || stop_hit) begin
                    state_nxt = sec_bus_pkg::ST_END;
                end
            end
            sec_bus_pkg::ST_END: begin
                state_nxt = sec_bus_pkg::ST_TURN;
            end
            sec_bus_pkg::ST_TURN: begin
                state_nxt = sec_bus_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = sec_bus_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= sec_bus_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Transaction bookkeeping
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_r <= 1'b0;
            left_r <= 4'h0;
            drop_r <= 4'h0;
            dev_cnt_r <= 3'h0;
            dev_seen_r <= 1'b0;
        end else begin
            if (start) begin
                wr_r <= cmd_write;
                left_r <= cmd_len;
            end else if (xfer) begin
                left_r <= left_r - 4'h1;
            end
            if (state_r == sec_bus_pkg::ST_TURN && wr_r) begin
                drop_r <= left_r;
            end else if (pop && state_r == sec_bus_pkg::ST_IDLE) begin
                drop_r <= drop_r - 4'h1;
            end
            if (state_r == sec_bus_pkg::ST_ADDR) begin
                dev_cnt_r <= 3'h1;
                dev_seen_r <= 1'b0;
            end else if (state_r == sec_bus_pkg::ST_DATA) begin
                dev_seen_r <= dev_seen_r | ~devsel_n_i;
                if (dev_cnt_r != sec_bus_pkg::DEVSEL_LIMIT) begin
                    dev_cnt_r <= dev_cnt_r + 3'h1;
                end
            end
        end
    end

    // Frame and initiator ready
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frame_act_r <= 1'b0;
            irdy_act_r <= 1'b0;
            ctl_oe_r <= 1'b0;
        end else begin
            case (state_nxt)
                sec_bus_pkg::ST_ADDR: begin
                    frame_act_r <= 1'b1;
                    ctl_oe_r <= 1'b1;
                end
                sec_bus_pkg::ST_DATA: begin
                    if (state_r == sec_bus_pkg::ST_ADDR || (wr_r && !irdy_act_r)) begin
                        irdy_act_r <= 1'b1;
                        frame_act_r <= (left_r > 4'h1);
                    end else if (xfer && wr_r) begin
                        irdy_act_r <= 1'b0;
                    end else if (xfer) begin
                        frame_act_r <= (left_r > 4'h2);
                    end
                end
                sec_bus_pkg::ST_END: begin
                    frame_act_r <= 1'b0;
                    irdy_act_r <= 1'b1;
                end
                sec_bus_pkg::ST_TURN: begin
                    frame_act_r <= 1'b0;
                    irdy_act_r <= 1'b0;
                end
                default: begin
                    frame_act_r <= 1'b0;
                    irdy_act_r <= 1'b0;
                    ctl_oe_r <= 1'b0;
                end
            endcase
        end
    end
    assign frame_n_o = ~frame_act_r;
    assign frame_n_oe = ctl_oe_r;
    assign irdy_n_o = ~irdy_act_r;
    assign irdy_n_oe = ctl_oe_r;

    // Address/data and command/byte enable drive, including parking
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ad_r <= sec_bus_pkg::PARK_AD;
            cbe_r <= sec_bus_pkg::PARK_CBE;
            ad_oe_r <= 1'b0;
            cbe_oe_r <= 1'b0;
        end else begin
            case (state_nxt)
                sec_bus_pkg::ST_ADDR: begin
                    ad_r <= cmd_addr;
                    cbe_r <= cmd_code;
                    ad_oe_r <= 1'b1;
                    cbe_oe_r <= 1'b1;
                end
                sec_bus_pkg::ST_DATA, sec_bus_pkg::ST_END: begin
                    if (!wr_r) begin
                        ad_oe_r <= 1'b0;
                        cbe_r <= cmd_be;
                    end else if (!irdy_act_r && !xfer) begin
                        ad_r <= head[31:0];
                        cbe_r <= head[35:32];
                    end
                end
                sec_bus_pkg::ST_TURN: begin
                    ad_oe_r <= 1'b0;
                    cbe_oe_r <= 1'b0;
                end
                default: begin
                    ad_r <= sec_bus_pkg::PARK_AD;
                    cbe_r <= sec_bus_pkg::PARK_CBE;
                    ad_oe_r <= own_gnt & bus_idle;
                    cbe_oe_r <= own_gnt & bus_idle;
                end
            endcase
        end
    end
    assign ad_o = ad_r;
    assign ad_oe = ad_oe_r;
    assign cbe_o = cbe_r;
    assign cbe_oe = cbe_oe_r;

    // Parity follows the driven word by one clock and is released one clock later
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            par_r <= 1'b0;
            par_oe_r <= 1'b0;
        end else begin
            par_r <= ^{ad_r, cbe_r};
            par_oe_r <= ad_oe_r | (cbe_oe_r & (state_r == sec_bus_pkg::ST_IDLE));
        end
    end
    assign par_o = par_r;
    assign par_oe = par_oe_r;

    // Read data capture and parity check
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= 32'h0000_0000;
            rd_valid_r <= 1'b0;
            chk_pend_r <= 1'b0;
            chk_ad_r <= 32'h0000_0000;
            chk_cbe_r <= 4'h0;
            perr_act_r <= 1'b0;
            perr_oe_r <= 1'b0;
        end else begin
            rd_valid_r <= xfer & ~wr_r;
            chk_pend_r <= xfer & ~wr_r;
            if (xfer && !wr_r) begin
                rd_data_r <= ad_i;
                chk_ad_r <= ad_i;
                chk_cbe_r <= cbe_i;
            end
            perr_act_r <= chk_pend_r & (^{chk_ad_r, chk_cbe_r, par_i});
            perr_oe_r <= (chk_pend_r & (^{chk_ad_r, chk_cbe_r, par_i})) | perr_act_r;
        end
    end
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign perr_n_o = ~perr_act_r;
    assign perr_n_oe = perr_oe_r;

    // Lock ownership across a locked sequence
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lock_own_r <= 1'b0;
            lock_rel_r <= 1'b0;
        end else begin
            lock_rel_r <= lock_own_r & ~lock_hold & (state_r == sec_bus_pkg::ST_IDLE);
            if (state_r == sec_bus_pkg::ST_ADDR && lock_hold) begin
                lock_own_r <= 1'b1;
            end else if (state_r == sec_bus_pkg::ST_IDLE && !lock_hold) begin
                lock_own_r <= 1'b0;
            end
        end
    end
    assign lock_n_o = ~lock_own_r;
    assign lock_n_oe = lock_own_r | lock_rel_r;

    // Status pulses and speed selection
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
            abort_r <= 1'b0;
            stop_r <= 1'b0;
            serr_r <= 1'b0;
            bus_perr_r <= 1'b0;
            clk66_r <= 1'b0;
        end else begin
            done_r <= (state_r == sec_bus_pkg::ST_TURN);
            abort_r <= (state_r == sec_bus_pkg::ST_DATA) & timeout & ~last_x;
            stop_r <= (state_r == sec_bus_pkg::ST_DATA) & stop_hit & ~timeout & ~last_x;
            serr_r <= ~serr_n_i;
            bus_perr_r <= ~perr_n_i & ~perr_oe_r;
            clk66_r <= p66_f & s66_f;
        end
    end
    assign done = done_r;
    assign master_abort = abort_r;
    assign target_stop = stop_r;
    assign perr_flag = perr_act_r;
    assign bus_perr = bus_perr_r;
    assign serr_flag = serr_r;
    assign clk_66_sel = clk66_r;
    assign s_m66en_o = 1'b0;
    assign s_m66en_oe = ~p66_f;

    // Arbiter: requests, hold-off after grant removal
    assign req_v[sec_bus_pkg::BRIDGE_IDX] = bridge_req;
    assign elig[sec_bus_pkg::BRIDGE_IDX] = bridge_req;
    genvar gi;
    generate
        for (gi = 0; gi < sec_bus_pkg::NAGT; gi++) begin : g_agent
            if (gi == 0) begin : g_zero
                assign req_v[gi] = ~sreq_n[gi] & ~ext_f;
            end else begin : g_other
                assign req_v[gi] = ~sreq_n[gi];
            end
            assign elig[gi] = req_v[gi] & ((hold_r[gi] == 2'h0) | gnt_r[gi]);
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    hold_r[gi] <= 2'h0;
                end else if (gnt_r[gi] && !gnt_nxt[gi]) begin
                    hold_r[gi] <= sec_bus_pkg::GNT_GAP;
                end else if (hold_r[gi] != 2'h0) begin
                    hold_r[gi] <= hold_r[gi] - 2'h1;
                end
            end
        end
    endgenerate

    always_comb begin
        int idx;
        idx = 0;
        pick = sec_bus_pkg::BRIDGE_IDX;
        found = 1'b0;
        for (int k = 1; k <= sec_bus_pkg::NARB; k++) begin
            idx = (int'(last_r) + k) % sec_bus_pkg::NARB;
            if (!found && elig[idx]) begin
                found = 1'b1;
                pick = 4'(idx);
            end
        end
    end

    assign rearb = (state_r == sec_bus_pkg::ST_IDLE) & bus_idle & (used_r | ~|(gnt_r & req_v));

    always_comb begin
        gnt_nxt = gnt_r;
        if (ext_f) begin
            gnt_nxt = 10'h000;
            gnt_nxt[0] = bridge_req & ((hold_r[0] == 2'h0) | gnt_r[0]);
        end else if (rearb) begin
            gnt_nxt = 10'h000;
            gnt_nxt[pick] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gnt_r <= 10'h000;
            last_r <= sec_bus_pkg::BRIDGE_IDX;
            used_r <= 1'b0;
        end else begin
            gnt_r <= gnt_nxt;
            if (!ext_f && rearb && found) begin
                last_r <= pick;
            end
            if (!frame_n_i) begin
                used_r <= 1'b1;
            end else if (rearb) begin
                used_r <= 1'b0;
            end
        end
    end
    assign gnt_n_o = ~gnt_r[8:0];
endmodule

// [dv/sec_bus_chk.sv]
// Timing checker for the secondary bus port
`timescale 1ns/1ps
module sec_bus_chk (
    input wire logic core_clk, // Clock
    input wire logic rstn, // Reset
    input wire logic [31:0] ad_o, // Data out
    input wire logic ad_oe, // Data enable
    input wire logic [3:0] cbe_o, // Enables out
    input wire logic par_o, // Parity out
    input wire logic par_oe, // Parity enable
    input wire logic frame_n_o, // Frame out
    input wire logic frame_n_oe, // Frame enable
    input wire logic irdy_n_o, // Ready out
    input wire logic irdy_n_oe, // Ready enable
    input wire logic trdy_n_i, // Target ready
    input wire logic devsel_n_i, // Select
    input wire logic stop_n_i, // Stop
    input wire logic perr_n_o, // Error out
    input wire logic perr_n_oe, // Error enable
    input wire logic master_abort // Abort pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    chk_par_even: assert property (par_oe |-> par_o == ^{$past(ad_o), $past(cbe_o)})
        else $error("parity wrong");
    chk_par_lag: assert property ($fell(ad_oe) |-> par_oe ##1 !par_oe)
        else $error("parity release");
    chk_frame_high: assert property ($fell(frame_n_oe) |-> $past(frame_n_o))
        else $error("frame released low");
    chk_irdy_high: assert property ($fell(irdy_n_oe) |-> $past(irdy_n_o))
        else $error("irdy released low");
    chk_irdy_hold: assert property (!irdy_n_o && irdy_n_oe && trdy_n_i && !devsel_n_i && stop_n_i |=> !irdy_n_o)
        else $error("irdy dropped");
    chk_frame_final: assert property ($rose(frame_n_o) && frame_n_oe |-> !irdy_n_o)
        else $error("frame end without irdy");
    chk_abort_time: assert property ($fell(frame_n_o) && devsel_n_i ##1 devsel_n_i[*5] |-> ##[1:3] master_abort)
        else $error("no abort");
    chk_perr_pulse: assert property ($fell(perr_n_o) && perr_n_oe |=> perr_n_o && perr_n_oe ##1 !perr_n_oe)
        else $error("perr shape");
    cover property (master_abort);
    cover property (perr_n_oe && !perr_n_o);
    cover property (!stop_n_i && !irdy_n_o);
endmodule
bind secondary_bus_port sec_bus_chk u_chk (.*);

// [dv/tgt_model.sv]
// Behavioural target on the secondary bus
`timescale 1ns/1ps
module tgt_model (
    input wire logic clk, // Bus clock
    input wire logic frame_n, // Bus frame
    input wire logic irdy_n, // Bus initiator ready
    input wire logic [31:0] ad_bus, // Bus data
    input wire logic [3:0] cbe, // Bus enables
    input wire logic [1:0] mode, // 0 ok, 1 silent, 2 stop, 3 bad parity
    output logic devsel_n, // Select
    output logic trdy_n, // Ready
    output logic stop_n, // Stop
    output logic [31:0] ad = 32'h0, // Read data
    output logic par = 1'b0 // Read parity
);
    logic act = 1'b0;
    assign devsel_n = !act;
    assign trdy_n = !act;
    assign stop_n = !(act && mode == 2'h2);
    always @(posedge clk) begin
        act <= act ? !(frame_n && irdy_n) : !frame_n && mode != 2'h1;
        ad <= (act || (!frame_n && mode != 2'h1)) ? 32'h5a5a_00c3 : ~ad;
        par <= ^{ad_bus, cbe} ^ (mode == 2'h3);
    end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the secondary bus port
`timescale 1ns/1ps
module testbench;
    logic core_clk = 0;
    logic rstn = 0;
    logic [31:0] ad_o, ad_i, cmd_addr, wr_data, rd_data, tad, rd_last;
    logic [3:0] cbe_o, cbe_i, cmd_code, cmd_be, cmd_len, wr_be;
    logic [8:0] sreq_n, gnt_n_o;
    logic [1:0] mode;
    logic ad_oe, cbe_oe, par_i, par_o, par_oe, frame_n_i, frame_n_o, frame_n_oe, irdy_n_i, irdy_n_o, irdy_n_oe;
    logic trdy_n_i, devsel_n_i, stop_n_i, lock_n_i, lock_n_o, lock_n_oe, perr_n_i, perr_n_o, perr_n_oe, tpar;
    logic serr_n_i, ext_arb, p_m66en, s_m66en_i, s_m66en_o, s_m66en_oe, clk_66_sel, cmd_valid, cmd_ready;
    logic cmd_write, lock_hold, wr_valid, wr_ready, rd_valid, done, master_abort, target_stop;
    logic perr_flag, bus_perr, serr_flag, perr_ext;
    int bad_count, checks, nd, na, ns, np, nse, nbp;
    assign ad_i = ad_oe ? ad_o : tad;
    assign cbe_i = cbe_oe ? cbe_o : 4'hf;
    assign par_i = par_oe ? par_o : tpar;
    assign frame_n_i = frame_n_oe ? frame_n_o : 1'b1;
    assign irdy_n_i = irdy_n_oe ? irdy_n_o : 1'b1;
    assign lock_n_i = lock_n_oe ? lock_n_o : 1'b1;
    assign perr_n_i = perr_n_oe ? perr_n_o : perr_ext;
    assign s_m66en_i = !s_m66en_oe;
    secondary_bus_port uut (.*);
    tgt_model tgt (.clk(core_clk), .frame_n(frame_n_i), .irdy_n(irdy_n_i), .ad_bus(ad_i), .cbe(cbe_i),
        .mode(mode), .devsel_n(devsel_n_i), .trdy_n(trdy_n_i), .stop_n(stop_n_i), .ad(tad), .par(tpar));
    always #12.5 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        nd += done;
        na += master_abort;
        ns += target_stop;
        np += perr_flag;
        nse += serr_flag;
        nbp += bus_perr;
        if (rd_valid) rd_last = rd_data;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [31:0] d);
        @(posedge core_clk) begin wr_valid <= 1; wr_data <= d; end
        repeat (20) begin @(negedge core_clk); if (wr_ready) break; end
        cmp(wr_ready, 1);
        @(posedge core_clk) wr_valid <= 0;
    endtask
    task automatic xact(input logic w, input logic [3:0] n, input logic [1:0] m);
        int t;
        t = nd + na;
        @(posedge core_clk) begin mode <= m; cmd_write <= w; cmd_len <= n; cmd_valid <= 1; end
        repeat (50) begin @(negedge core_clk); if (cmd_ready) break; end
        cmp(cmd_ready, 1);
        @(posedge core_clk) cmd_valid <= 0;
        repeat (60) begin @(negedge core_clk); if (nd + na != t) break; end
        cmp(nd + na - t, 1);
        repeat (6) @(posedge core_clk);
    endtask
    task automatic t_write; push(32'h1234_5678); push(32'h0f0f_a5a5); xact(1, 4'h2, 2'h0); cmp(nd, 1); endtask
    task automatic t_read; xact(0, 4'h1, 2'h0); cmp(rd_last, 32'h5a5a_00c3); endtask
    task automatic t_abort; xact(0, 4'h1, 2'h1); cmp(na, 1); endtask
    task automatic t_stop; xact(0, 4'h4, 2'h2); cmp(ns, 1); endtask
    task automatic t_perr; xact(0, 4'h1, 2'h3); cmp(np, 1); endtask
    task automatic t_lock;
        @(posedge core_clk) lock_hold <= 1;
        xact(0, 4'h1, 2'h0);
        cmp({lock_n_oe, lock_n_o}, 2'b10);
        @(posedge core_clk) lock_hold <= 0;
        repeat (3) @(posedge core_clk);
        cmp(lock_n_oe, 0);
    endtask
    task automatic t_arb;
        @(posedge core_clk) sreq_n <= 9'h1f7;
        repeat (3) @(posedge core_clk);
        cmp(gnt_n_o, 9'h1f7);
        sreq_n <= '1;
        @(posedge core_clk) sreq_n <= 9'h1f7;
        repeat (2) @(posedge core_clk);
        cmp(gnt_n_o, 9'h1ff);
        repeat (3) @(posedge core_clk);
        cmp(gnt_n_o, 9'h1f7);
        @(posedge core_clk) sreq_n <= '1;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic t_ext;
        int t;
        t = nd;
        @(posedge core_clk) ext_arb <= 1;
        repeat (6) @(posedge core_clk);
        fork
            xact(0, 4'h1, 2'h0);
            begin
                repeat (3) @(posedge core_clk);
                cmp(gnt_n_o, 9'h1fe);
                cmp(cmd_ready, 0);
                sreq_n <= 9'h1fe;
            end
        join
        cmp(nd, t + 1);
        @(posedge core_clk) begin ext_arb <= 0; sreq_n <= '1; end
        repeat (6) @(posedge core_clk);
    endtask
    task automatic t_misc;
        cmp(clk_66_sel, 1);
        @(posedge core_clk) begin p_m66en <= 0; serr_n_i <= 0; perr_ext <= 0; end
        @(posedge core_clk) begin serr_n_i <= 1; perr_ext <= 1; end
        repeat (8) @(posedge core_clk);
        cmp(s_m66en_oe, 1);
        cmp(clk_66_sel, 0);
        cmp(nse, 1);
        cmp(nbp, 1);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {cmd_valid, cmd_write, lock_hold, wr_valid, ext_arb} = 0;
        {serr_n_i, p_m66en, perr_ext, sreq_n} = '1;
        {cmd_addr, wr_data, mode} = {32'h0000_1000, 32'h0, 2'h0};
        {cmd_code, cmd_be, cmd_len, wr_be} = {4'h6, 4'h0, 4'h1, 4'h0};
        repeat (5) @(posedge core_clk);
        rstn <= 1;
        repeat (6) @(posedge core_clk);
        t_write;
        t_read;
        t_abort;
        t_stop;
        t_perr;
        t_lock;
        t_arb;
        t_ext;
        t_misc;
        stop_test;
    end
    initial begin
        #200us;
        bad_count++;
        $display("[FAIL] %0t: watchdog expired", $time);
        stop_test;
    end
endmodule
